// *** rtl/csrs_clock_guard.v ***
// Clock guard: spike filter, loss detector and glitch-free fallback mux
`timescale 1ns/100ps
`include "csrs_regs.vh"
module csrs_clock_guard #(
  parameter LOSS_CYC = `CSRS_LOSS_CYC,
  parameter FMIN_CYC = `CSRS_FMIN_CYC
) (
  sys_clk,
  nrst,
  guardOn,
  mainClkSync,
  backupTick,
  mainClkPass,
  onBackup,
  clkOut
);
  input  wire sys_clk;
  input  wire nrst;
  input  wire guardOn;
  input  wire mainClkSync;
  input  wire backupTick;
  output reg  mainClkPass;
  output reg  onBackup;
  output reg  clkOut;

  reg       prevMain_reg;
  reg [7:0] gapCnt_reg;
  reg [7:0] lossCnt_reg;
  reg       backupLvl_reg;
  reg       spike;
  wire      mainEdge;
  wire      nextLvl;

  assign mainEdge = mainClkSync ^ prevMain_reg;

  always @* begin
    spike = mainEdge && (gapCnt_reg < FMIN_CYC[7:0]);
  end

  // Output level only flips on a valid edge, so no shortened phase can reach clkOut
  assign nextLvl = onBackup ? backupLvl_reg : mainClkPass;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prevMain_reg  <= 1'b0;
      gapCnt_reg    <= 8'h00;
      lossCnt_reg   <= 8'h00;
      backupLvl_reg <= 1'b0;
      mainClkPass   <= 1'b0;
      onBackup      <= 1'b0;
      clkOut        <= 1'b0;
    end else if (!guardOn) begin
      prevMain_reg <= mainClkSync;
      mainClkPass  <= mainClkSync;
      onBackup     <= 1'b0;
      lossCnt_reg  <= 8'h00;
      clkOut       <= mainClkSync;
    end else begin
      prevMain_reg <= mainClkSync;
      if (mainEdge)
        gapCnt_reg <= 8'h00;
      else if (gapCnt_reg != 8'hFF)
        gapCnt_reg <= gapCnt_reg + 8'h01;
      if (mainEdge && !spike) begin
        mainClkPass <= mainClkSync;
        lossCnt_reg <= 8'h00;
        if (onBackup && !backupLvl_reg && !mainClkSync)
          onBackup <= 1'b0;
      end else if (lossCnt_reg >= LOSS_CYC[7:0]) begin
        // Switch as backup falls: a stuck-high main ends cleanly, low phase is full
        if (!onBackup && backupTick && backupLvl_reg)
          onBackup <= 1'b1;
      end else begin
        lossCnt_reg <= lossCnt_reg + 8'h01;
      end
      if (backupTick)
        backupLvl_reg <= ~backupLvl_reg;
      clkOut <= nextLvl;
    end
  end
endmodule // csrs_clock_guard

// *** rtl/csrs_regs.vh ***
// Constants for the clock security and reset source block
`ifndef CSRS_REGS_VH
`define CSRS_REGS_VH
`define CSRS_SRC_EXTCLK     3'h0
`define CSRS_SRC_RES0       3'h1
`define CSRS_SRC_RES1       3'h2
`define CSRS_SRC_RES2       3'h3
`define CSRS_SRC_RES3       3'h4
`define CSRS_SRC_EXTRC      3'h5
`define CSRS_SRC_INTRC      3'h6
`define CSRS_SRC_SPARE      3'h7
`define CSRS_OPT_SRC_DEFAULT 3'h0
`define CSRS_MISC_SMS       0
`define CSRS_MISC_CP0       1
`define CSRS_MISC_CP1       2
`define CSRS_MISC_MCO       5
`define CSRS_MISC_RESET     8'h00
`define CSRS_STAT_WATCHDOG_RESET_FLAG     0
`define CSRS_STAT_BKDET     1
`define CSRS_STAT_IRQEN     2
`define CSRS_STAT_SDRF      4
`define CSRS_STAT_RESET     8'h00
`define CSRS_STAT_RMASK     8'h17
`define CSRS_CLK_MHZ        20
`define CSRS_RSTOUT_NS      1000
`define CSRS_RSTOUT_CYC     ((`CSRS_RSTOUT_NS * `CSRS_CLK_MHZ + 999) / 1000)
`define CSRS_GLITCH_NS      200
`define CSRS_GLITCH_CYC     ((`CSRS_GLITCH_NS * `CSRS_CLK_MHZ + 999) / 1000)
`define CSRS_LOSS_CYC       16
`define CSRS_FMIN_CYC       2
`define CSRS_BACKUP_DIV     8
`endif

// *** rtl/csrs_top.v ***
// Clock supply, clock guard, prescaler and reset source logic
`timescale 1ns/100ps
`include "csrs_regs.vh"
module csrs_top #(
  parameter [2:0] OPT_SRC_DEFAULT = `CSRS_OPT_SRC_DEFAULT,
  parameter       LOSS_CYC        = `CSRS_LOSS_CYC,
  parameter       FMIN_CYC        = `CSRS_FMIN_CYC,
  parameter       BACKUP_DIV      = `CSRS_BACKUP_DIV
) (
  sys_clk,
  nrst,
  optValid,
  optSrcSel,
  optGuardEn,
  oscClkIn,
  supplyLow,
  wdgUnderflow,
  rstPinIn,
  lightSleep,
  deepHalt,
  haltWakeIrq,
  cpuIrqMask,
  miscWrEn,
  miscWrData,
  statWrEn,
  statWrData,
  statRdEn,
  statRdData,
  miscRdData,
  rstPinOut,
  rstPinOe,
  resonatorRun,
  oscSrcSel,
  sysClkOut,
  cpuClkEn,
  clkOutPin,
  clkOutPinEnN,
  guardIrq,
  guardWake
);
  input  wire       sys_clk;
  input  wire       nrst;
  input  wire       optValid;
  input  wire [2:0] optSrcSel;
  input  wire       optGuardEn;
  input  wire       oscClkIn;
  input  wire       supplyLow;
  input  wire       wdgUnderflow;
  input  wire       rstPinIn;
  input  wire       lightSleep;
  input  wire       deepHalt;
  input  wire       haltWakeIrq;
  input  wire       cpuIrqMask;
  input  wire       miscWrEn;
  input  wire [7:0] miscWrData;
  input  wire       statWrEn;
  input  wire [7:0] statWrData;
  input  wire       statRdEn;
  output reg  [7:0] statRdData;
  output reg  [7:0] miscRdData;
  output reg        rstPinOut;
  output reg        rstPinOe;
  output reg        resonatorRun;
  output reg  [2:0] oscSrcSel;
  output reg        sysClkOut;
  output reg        cpuClkEn;
  output reg        clkOutPin;
  output reg        clkOutPinEnN;
  output reg        guardIrq;
  output reg        guardWake;

  localparam RST_CNT_MAX = `CSRS_RSTOUT_CYC;
  localparam GLT_CNT_MAX = `CSRS_GLITCH_CYC;

  reg        oscSync1_reg, oscSync2_reg;
  reg        supSync1_reg, supSync2_reg;
  reg        wdgSync1_reg, wdgSync2_reg, wdgPrev_reg;
  reg        rpinSync1_reg, rpinSync2_reg;
  reg [7:0]  gltCnt_reg;
  reg        supplyBad_reg;
  reg [7:0]  rstCnt_reg;
  reg        optTaken_reg;
  reg        guardOn_reg;
  reg [7:0]  misc_control_reg;
  reg        supply_drop_reset_flag;
  reg        watchdog_reset_flag;
  reg        backup_clock_detected_flag;
  reg        clock_guard_irq_enable;
  reg [7:0]  bkDiv_reg;
  reg        bkTick_reg;
  reg        onBackupPrev_reg;
  reg [5:0]  preCnt_reg;
  reg [5:0]  preLimit;
  reg        clkPrev_reg;
  wire       guardActive;
  wire       wdgEvent;
  wire       onBackup;
  wire       guardClk;
  wire       clkRise;
  wire [7:0] statNow;

  function [5:0] divFor;
    input [7:0] misc;
    begin
      if (misc[`CSRS_MISC_SMS])
        divFor = 6'd31;
      else
        case ({misc[`CSRS_MISC_CP1], misc[`CSRS_MISC_CP0]})
          2'b00:   divFor = 6'd1;
          2'b01:   divFor = 6'd3;
          2'b10:   divFor = 6'd7;
          2'b11:   divFor = 6'd15;
          default: divFor = 6'd1;
        endcase
    end
  endfunction

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oscSync1_reg  <= 1'b0;
      oscSync2_reg  <= 1'b0;
      supSync1_reg  <= 1'b1;
      supSync2_reg  <= 1'b1;
      wdgSync1_reg  <= 1'b0;
      wdgSync2_reg  <= 1'b0;
      wdgPrev_reg   <= 1'b0;
      rpinSync1_reg <= 1'b1;
      rpinSync2_reg <= 1'b1;
    end else begin
      oscSync1_reg  <= oscClkIn;
      oscSync2_reg  <= oscSync1_reg;
      supSync1_reg  <= supplyLow;
      supSync2_reg  <= supSync1_reg;
      wdgSync1_reg  <= wdgUnderflow;
      wdgSync2_reg  <= wdgSync1_reg;
      wdgPrev_reg   <= wdgSync2_reg;
      rpinSync1_reg <= rstPinIn;
      rpinSync2_reg <= rpinSync1_reg;
    end
  end

  assign wdgEvent = wdgSync2_reg && !wdgPrev_reg;

  // Supply state changes only after it is stable for the glitch time
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gltCnt_reg    <= 8'h00;
      supplyBad_reg <= 1'b1;
    end else if (supSync2_reg == supplyBad_reg) begin
      gltCnt_reg <= 8'h00;
    end else if (gltCnt_reg >= GLT_CNT_MAX[7:0] - 8'h01) begin
      gltCnt_reg    <= 8'h00;
      supplyBad_reg <= supSync2_reg;
    end else begin
      gltCnt_reg <= gltCnt_reg + 8'h01;
    end
  end

  // Reset pin: low while supply bad, or for minimum pulse after watchdog
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstCnt_reg <= 8'h00;
      rstPinOut  <= 1'b0;
      rstPinOe   <= 1'b0;
    end else begin
      if (wdgEvent)
        rstCnt_reg <= RST_CNT_MAX[7:0];
      else if (rstCnt_reg != 8'h00)
        rstCnt_reg <= rstCnt_reg - 8'h01;
      rstPinOut <= 1'b0;
      rstPinOe  <= !(supplyBad_reg || wdgEvent || rstCnt_reg > 8'h01);
    end
  end

  // Option byte is taken once after release, then held until next reset
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      optTaken_reg <= 1'b0;
      oscSrcSel    <= `CSRS_OPT_SRC_DEFAULT;
      guardOn_reg  <= 1'b0;
      resonatorRun <= 1'b0;
    end else begin
      if (optValid && !optTaken_reg) begin
        optTaken_reg <= 1'b1;
        oscSrcSel    <= (optSrcSel == `CSRS_SRC_SPARE) ? OPT_SRC_DEFAULT : optSrcSel;
        guardOn_reg  <= optGuardEn;
      end
      resonatorRun <= (oscSrcSel >= `CSRS_SRC_RES0) &&
                      (oscSrcSel <= `CSRS_SRC_RES3);
    end
  end

  assign guardActive = guardOn_reg && !deepHalt;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bkDiv_reg  <= 8'h00;
      bkTick_reg <= 1'b0;
    end else if (!guardActive) begin
      bkDiv_reg  <= 8'h00;
      bkTick_reg <= 1'b0;
    end else if (bkDiv_reg >= BACKUP_DIV[7:0] - 8'h01) begin
      bkDiv_reg  <= 8'h00;
      bkTick_reg <= 1'b1;
    end else begin
      bkDiv_reg  <= bkDiv_reg + 8'h01;
      bkTick_reg <= 1'b0;
    end
  end

  csrs_clock_guard #(
    .LOSS_CYC (LOSS_CYC),
    .FMIN_CYC (FMIN_CYC)
  ) uGuard (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .guardOn     (guardActive),
    .mainClkSync (oscSync2_reg),
    .backupTick  (bkTick_reg),
    .mainClkPass (),
    .onBackup    (onBackup),
    .clkOut      (guardClk)
  );

  assign statNow = {3'h0, supply_drop_reset_flag, 1'b0, clock_guard_irq_enable,
                    backup_clock_detected_flag, watchdog_reset_flag};

  // Status and control; frozen during halt, kept across halt wake
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      misc_control_reg           <= `CSRS_MISC_RESET;
      supply_drop_reset_flag     <= 1'b0;
      watchdog_reset_flag        <= 1'b0;
      backup_clock_detected_flag <= 1'b0;
      clock_guard_irq_enable     <= 1'b0;
      onBackupPrev_reg           <= 1'b0;
      statRdData                 <= `CSRS_STAT_RESET;
    end else if (!deepHalt) begin
      onBackupPrev_reg <= onBackup;
      if (miscWrEn)
        misc_control_reg <= miscWrData;
      if (statWrEn)
        clock_guard_irq_enable <= statWrData[`CSRS_STAT_IRQEN];
      if (supplyBad_reg)
        supply_drop_reset_flag <= 1'b1;
      else if (wdgEvent || (statWrEn && !statWrData[`CSRS_STAT_SDRF]))
        supply_drop_reset_flag <= 1'b0;
      if (wdgEvent)
        watchdog_reset_flag <= 1'b1;
      else if (supplyBad_reg || (statWrEn && !statWrData[`CSRS_STAT_WATCHDOG_RESET_FLAG]))
        watchdog_reset_flag <= 1'b0;
      if (onBackup && !onBackupPrev_reg)
        backup_clock_detected_flag <= 1'b1;
      else if (statRdEn && !onBackup)
        backup_clock_detected_flag <= 1'b0;
      if (statRdEn)
        statRdData <= statNow & `CSRS_STAT_RMASK;
    end
  end

  // Prescaler: one-cycle CPU enable pulse every limit+1 guarded clock rises
  assign clkRise = guardClk && !clkPrev_reg;

  always @* begin
    preLimit = divFor(misc_control_reg);
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clkPrev_reg  <= 1'b0;
      preCnt_reg   <= 6'd0;
      cpuClkEn     <= 1'b0;
      sysClkOut    <= 1'b0;
      clkOutPin    <= 1'b0;
      clkOutPinEnN <= 1'b1;
      miscRdData   <= `CSRS_MISC_RESET;
      guardIrq     <= 1'b0;
      guardWake    <= 1'b0;
    end else begin
      clkPrev_reg <= guardClk;
      sysClkOut   <= guardClk;
      cpuClkEn    <= 1'b0;
      if (clkRise) begin
        if (preCnt_reg >= preLimit) begin
          preCnt_reg <= 6'd0;
          cpuClkEn   <= 1'b1;
        end else begin
          preCnt_reg <= preCnt_reg + 6'd1;
        end
      end
      if (preCnt_reg > (preLimit >> 1))
        clkOutPin <= 1'b1;
      else
        clkOutPin <= 1'b0;
      clkOutPinEnN <= !misc_control_reg[`CSRS_MISC_MCO];
      miscRdData   <= misc_control_reg;
      guardIrq     <= backup_clock_detected_flag && clock_guard_irq_enable &&
                      !cpuIrqMask;
      guardWake    <= backup_clock_detected_flag && clock_guard_irq_enable &&
                      lightSleep && !deepHalt && !haltWakeIrq;
    end
  end
endmodule // csrs_top

// *** tb/clock_security_and_reset_sources_tb.sv ***
// Self-checking bench for the clock security and reset source block
`timescale 1ns/100ps
module clock_security_and_reset_sources_tb;
  reg        sys_clk = 1'b0;
  reg        nrst = 1'b0;
  reg  [2:0] optSrcSel = 3'h0;
  reg        oscRun = 1'b1;
  reg        oscFast = 1'b0;
  reg        supplyLow = 1'b0;
  reg        wdgUnderflow = 1'b0;
  reg        lightSleep = 1'b0;
  reg        deepHalt = 1'b0;
  reg        haltWakeIrq = 1'b0;
  reg        cpuIrqMask = 1'b1;
  reg        miscWrEn = 1'b0;
  reg        statWrEn = 1'b0;
  reg  [7:0] wrData = 8'h00;
  reg        statRdEn = 1'b0;
  reg        rdPend = 1'b0;
  reg  [7:0] miscVal;
  reg        optGuardEn = 1'b1;
  reg        sysPrev = 1'b0;
  reg        pinPrev = 1'b0;
  reg        divArm = 1'b0;
  wire       cpuClkEn;
  wire       clkOutPin;
  int        riseCnt = 0;
  int        pinCnt = 0;
  logic [7:0] divQ[$];
  wire       oscClk;
  wire       rstPinLevel;
  wire [7:0] statRdData;
  wire [7:0] miscRdData;
  wire       rstPinOut;
  wire       rstPinOe;
  wire       resonatorRun;
  wire [2:0] oscSrcSel;
  wire       sysClkOut;
  wire       clkOutPinEnN;
  wire       guardIrq;
  wire       guardWake;
  int        err_count = 0;
  int        tests_run = 0;
  int        cycCnt = 0;
  logic [7:0] expQ[$];

  always #25 sys_clk = ~sys_clk;
  // Pull-up on the reset pin when nobody drives it
  assign rstPinLevel = rstPinOe ? 1'b1 : rstPinOut;

  csrs_osc_model u_osc (.run(oscRun), .fast(oscFast), .oscClk(oscClk));

  csrs_top u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .optValid(1'b1), .optSrcSel(optSrcSel),
    .optGuardEn(optGuardEn), .oscClkIn(oscClk), .supplyLow(supplyLow),
    .wdgUnderflow(wdgUnderflow), .rstPinIn(rstPinLevel), .lightSleep(lightSleep),
    .deepHalt(deepHalt), .haltWakeIrq(haltWakeIrq), .cpuIrqMask(cpuIrqMask),
    .miscWrEn(miscWrEn), .miscWrData(wrData), .statWrEn(statWrEn),
    .statWrData(wrData), .statRdEn(statRdEn), .statRdData(statRdData),
    .miscRdData(miscRdData), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .resonatorRun(resonatorRun), .oscSrcSel(oscSrcSel), .sysClkOut(sysClkOut),
    .cpuClkEn(cpuClkEn), .clkOutPin(clkOutPin), .clkOutPinEnN(clkOutPinEnN),
    .guardIrq(guardIrq),
    .guardWake(guardWake)
  );

  task summarize;
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input bit misc, input [7:0] d);
    @(negedge sys_clk);
    miscWrEn = misc;
    statWrEn = !misc;
    wrData = d;
    @(negedge sys_clk);
    miscWrEn = 1'b0;
    statWrEn = 1'b0;
  endtask
  task rd(input [7:0] e);
    @(negedge sys_clk);
    statRdEn = 1'b1;
    expQ.push_back(e);
    @(negedge sys_clk);
    statRdEn = 1'b0;
  endtask
  task rst(input [2:0] s);
    nrst = 1'b0;
    optSrcSel = s;
    cyc(4);
    nrst = 1'b1;
    cyc(10);
  endtask
  task pulse(input bit sup, input int n);
    supplyLow = sup;
    wdgUnderflow = !sup;
    cyc(n);
    supplyLow = 1'b0;
    wdgUnderflow = 1'b0;
    cyc(30);
  endtask

  // Status data lands one cycle after the read strobe
  always @(posedge sys_clk) begin
    if (rdPend) begin
      check("statRdData", statRdData, expQ.pop_front());
    end
    rdPend <= statRdEn;
    // Prescale period in guarded clock rises; first pulse after a change is skipped
    if (sysClkOut && !sysPrev)
      riseCnt++;
    if (clkOutPin && !pinPrev)
      pinCnt++;
    sysPrev <= sysClkOut;
    pinPrev <= clkOutPin;
    if (cpuClkEn) begin
      if (divArm && divQ.size() > 0) begin
        check("cpuClkEn", 8'(riseCnt), divQ.pop_front());
        check("clkOutPin", 8'(pinCnt), 8'h01);
      end
      divArm = divQ.size() > 0;
      riseCnt = 0;
      pinCnt = 0;
    end
    cycCnt++;
    if (cycCnt == 20000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    void'($urandom(32'hA70D));
    for (int s = 0; s < 8; s++) begin
      rst(s[2:0]);
      check("oscSrcSel", {5'h00, oscSrcSel}, (s == 7) ? 8'h00 : s[7:0]);
      check("resonatorRun", {7'h00, resonatorRun}, {7'h00, s >= 1 && s <= 4});
    end
    rst(3'(1 + $urandom % 4));
    miscVal = 8'($urandom) | 8'h20;
    wr(1'b1, miscVal);
    cyc(3);
    check("miscRdData", miscRdData, miscVal);
    check("clkOutPinEnN", {7'h00, clkOutPinEnN}, 8'h00);
    divQ.push_back(miscVal[0] ? 8'h20 : (8'h02 << miscVal[2:1]));
    divQ.push_back(miscVal[0] ? 8'h20 : (8'h02 << miscVal[2:1]));
    wait (divQ.size() == 0);
    cyc(1);
    pulse(1'b0, 3);
    rd(8'h01);
    pulse(1'b1, 20);
    rd(8'h10);
    pulse(1'b0, 3);
    rd(8'h01);
    wr(1'b0, 8'h04);
    rd(8'h04);
    pulse(1'b1, 2);
    rd(8'h04);
    oscRun = 1'b0;
    cyc(60);
    check("guardIrq", {7'h00, guardIrq}, 8'h00);
    rd(8'h06);
    rd(8'h06);
    cpuIrqMask = 1'b0;
    cyc(3);
    check("guardIrq", {7'h00, guardIrq}, 8'h01);
    oscRun = 1'b1;
    cyc(60);
    rd(8'h06);
    rd(8'h04);
    cyc(3);
    check("guardIrq", {7'h00, guardIrq}, 8'h00);
    deepHalt = 1'b1;
    cyc(2);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h00);
    cyc(2);
    deepHalt = 1'b0;
    haltWakeIrq = 1'b1;
    cyc(2);
    haltWakeIrq = 1'b0;
    check("miscRdData", miscRdData, miscVal);
    rd(8'h04);
    lightSleep = 1'b1;
    oscRun = 1'b0;
    cyc(60);
    check("guardWake", {7'h00, guardWake}, 8'h01);
    oscRun = 1'b1;
    cyc(60);
    rd(8'h06);
    lightSleep = 1'b0;
    oscFast = 1'b1;
    cyc(60);
    rd(8'h06);
    rd(8'h06);
    oscFast = 1'b0;
    cyc(60);
    rd(8'h06);
    rd(8'h04);
    cyc(2);
    optGuardEn = 1'b0;
    rst(3'h1);
    check("miscRdData", miscRdData, 8'h00);
    oscRun = 1'b0;
    cyc(60);
    rd(8'h10);
    cyc(2);
    summarize();
  end
endmodule // clock_security_and_reset_sources_tb

// *** tb/csrs_monitor.sv ***
// Port-level checks for the clock security and reset source block
`timescale 1ns/100ps
module csrs_monitor (
  input wire       sys_clk,
  input wire       nrst,
  input wire       supplyLow,
  input wire       wdgUnderflow,
  input wire       deepHalt,
  input wire       cpuIrqMask,
  input wire [7:0] miscRdData,
  input wire       rstPinOut,
  input wire       rstPinOe,
  input wire       resonatorRun,
  input wire [2:0] oscSrcSel,
  input wire       sysClkOut,
  input wire       clkOutPinEnN,
  input wire       guardIrq,
  input wire       guardWake
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  AST_RST_OPEN_DRAIN: assert property (rstPinOut == 1'b0)
    else $error("reset pin driven high");
  AST_SUPPLY_RESET: assert property (supplyLow [*8] |-> ##[0:4] !rstPinOe)
    else $error("supply low without reset drive");
  AST_WDG_PULSE: assert property ($rose(wdgUnderflow) |-> ##[2:6] !rstPinOe [*8])
    else $error("watchdog reset pulse too short");
  AST_NO_SPARE: assert property (oscSrcSel != 3'h7)
    else $error("spare source in use");
  AST_RESONATOR_RUN: assert property ($stable(oscSrcSel) [*2] |->
    resonatorRun == (oscSrcSel >= 3'h1 && oscSrcSel <= 3'h4))
    else $error("resonator run mismatch");
  // Phases of one cycle would mean a spike or a runt slipped through
  AST_NO_RUNT: assert property ($changed(sysClkOut) |=> $stable(sysClkOut))
    else $error("short system clock phase");
  AST_IRQ_MASKED: assert property (cpuIrqMask [*2] |-> !guardIrq)
    else $error("interrupt while masked");
  AST_HALT_NO_WAKE: assert property (deepHalt [*2] |-> !guardWake)
    else $error("guard wake in halt");
  AST_HALT_FROZEN: assert property (deepHalt [*3] |-> $stable(miscRdData))
    else $error("control changed in halt");
  AST_CLKOUT_EN: assert property ($stable(miscRdData[5]) [*3] |->
    clkOutPinEnN == !miscRdData[5])
    else $error("clock output enable mismatch");

  COV_IRQ: cover property (guardIrq);
  COV_WDG: cover property ($rose(wdgUnderflow) ##6 !rstPinOe);
  COV_CLKOUT: cover property (!clkOutPinEnN);
endmodule // csrs_monitor

bind csrs_top csrs_monitor u_mon (
  .sys_clk(sys_clk), .nrst(nrst), .supplyLow(supplyLow), .wdgUnderflow(wdgUnderflow),
  .deepHalt(deepHalt), .cpuIrqMask(cpuIrqMask), .miscRdData(miscRdData),
  .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .resonatorRun(resonatorRun),
  .oscSrcSel(oscSrcSel), .sysClkOut(sysClkOut), .clkOutPinEnN(clkOutPinEnN),
  .guardIrq(guardIrq), .guardWake(guardWake)
);

// *** tb/csrs_osc_model.sv ***
// Behavioural main oscillator feeding the clock guard
`timescale 1ns/100ps
module csrs_osc_model (
  input  wire run,
  input  wire fast,
  output reg  oscClk
);
  // A dead crystal holds its last level; fast mode mimics a harmonic
  // Offset keeps every toggle clear of a system clock edge
  initial begin
    oscClk = 1'b0;
    #2;
    forever begin
      #(fast ? 20 : 175);
      if (run) begin
        oscClk = ~oscClk;
      end
    end
  end
endmodule // csrs_osc_model
